// [hw/e1_alarm_regs.vh]
// constants for the per-link alarm, criteria and monitor register bank
// assumes a 20 MHz core clock and register indices multiplied by four on APB
`ifndef E1_ALARM_REGS_VH
`define E1_ALARM_REGS_VH
// register indices inside one link page
`define IDX_ALARM_STATUS   8'hb9
`define IDX_ALARM_ENABLE   8'hba
`define IDX_ALARM_FLAGS    8'hbb
`define IDX_CRITERIA       8'hbc
`define IDX_SNAP_CTRL      8'hc2
`define IDX_OVF_ENABLE_0   8'hc3
`define IDX_OVF_ENABLE_1   8'hc4
`define IDX_OVF_FLAGS_0    8'hc5
`define IDX_OVF_FLAGS_1    8'hc6
// field positions
`define BIT_ALL_ONES_SEL   5
`define BIT_REMOTE_SEL     4
`define BIT_MANUAL_SNAP    5
`define BIT_AUTO_SNAP      4
`define RESET_BYTE         8'h00
// timing
`define CORE_CLK_KHZ       20000
`define RED_PERSIST_MS     100
`define SNAP_PERIOD_MS     1000
`define AIS_WINDOW_BITS    512
`define REMOTE_A_ONES      4
`define REMOTE_Y_ONES      3
`define TS16_RUN_OCTETS    16
`define TS16_PERIOD_FRAMES 16
`endif

// [hw/e1_alarm_performance_monitor_event_regs.v]
// per-link alarm change flags, criteria select, snapshot control and overflow flags
// assumes framer detector inputs are synchronous to core_clk_in, one APB master
// Overview of operation
// - each alarm status change in either direction sets its change flag, bits 5..0
// - change and overflow flags stay set until software writes a one there
// - all-ones select zero: under 3 zeros in window plus out-of-frame declares
// - all-ones select one: two consecutive windows needed to declare or clear
// - remote select zero: 4 consecutive A ones declare, one zero clears
// - remote select one: single A one declares, single A zero clears
// - manual snapshot bit rising edge updates all monitor counters at once
// - auto snapshot bit set updates monitor counters every one second
// - counter overflow sets its matching overflow flag, bits 7..0
// - overflow flag drives interrupt only when same-position enable is one
// - line-code overflow flag gated onto interrupt by enable bit 0
// - four independent register copies, pages 0 to 3, same low offsets
// - red status follows frame loss or alignment persisting 100 ms
// - multiframe remote status sets on 3 Y ones, clears on one zero
// - ts16 loss sets on 16 zero octets, clears on 16 nonzero octets
// - ts16 all-ones sets under 4 zeros twice, clears over 3 zeros once
//
// Implementation choice: the APB slave port.
`include "e1_alarm_regs.vh"
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// one link: detectors and registers
// ****************************************************************
module e1_link_bank #(
  parameter RED_CYCLES = `RED_PERSIST_MS * `CORE_CLK_KHZ
) (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       wr_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       sec_tick_in,
  input  wire       oof_in,
  input  wire       bit_valid_in,
  input  wire       bit_in,
  input  wire       a_valid_in,
  input  wire       a_bit_in,
  input  wire       y_valid_in,
  input  wire       y_bit_in,
  input  wire       ts16_valid_in,
  input  wire [7:0] ts16_octet_in,
  input  wire [7:0] ovf_in,
  input  wire       lcv_ovf_in,
  output reg  [7:0] rdata_out,
  output reg        hit_out,
  output wire       irq_out,
  output reg        snapshot_out
);
  reg  [5:0]  status_reg;
  reg  [5:0]  status_d_reg;
  reg  [5:0]  alarm_en_reg;
  reg  [5:0]  alarm_flags_reg;
  reg  [1:0]  crit_reg;
  reg  [1:0]  snap_ctrl_reg;
  reg  [7:0]  ovf_en0_reg;
  reg         ovf_en1_reg;
  reg  [7:0]  ovf_flags0_reg;
  reg         ovf_flags1_reg;
  reg  [24:0] red_cnt_reg;
  reg  [8:0]  win_cnt_reg;
  reg  [1:0]  win_zero_reg;
  reg         prev_low_reg;
  reg         prev_high_reg;
  reg  [2:0]  a_ones_reg;
  reg  [1:0]  y_ones_reg;
  reg  [4:0]  zrun_reg;
  reg  [4:0]  nzrun_reg;
  reg  [3:0]  frame_cnt_reg;
  reg  [2:0]  ts16_zero_reg;
  reg         prev_few_reg;
  reg  [1:0]  zc_now;
  reg  [3:0]  oct_zeros;
  reg  [3:0]  tz_sum;
  integer     i;
  wire        wr_flags  = wr_in && (addr_in == `IDX_ALARM_FLAGS);
  wire        wr_ovf0   = wr_in && (addr_in == `IDX_OVF_FLAGS_0);
  wire        wr_ovf1   = wr_in && (addr_in == `IDX_OVF_FLAGS_1);
  wire        wr_snap   = wr_in && (addr_in == `IDX_SNAP_CTRL);
  wire        ais_sel   = crit_reg[1];
  wire        rai_sel   = crit_reg[0];
  wire        win_end   = bit_valid_in && (win_cnt_reg == `AIS_WINDOW_BITS - 1);
  wire        win_low   = (zc_now < 2'd3);
  wire        per_end   = ts16_valid_in && (frame_cnt_reg == `TS16_PERIOD_FRAMES - 1);
  wire        per_few   = (tz_sum < 4'd4);

  // zero counts of the current bit and octet
  always @*
  begin
    zc_now = win_zero_reg;
    if (!bit_in && win_zero_reg != 2'd3)
      zc_now = win_zero_reg + 2'd1;
    oct_zeros = 4'd0;
    for (i = 0; i < 8; i = i + 1)
      oct_zeros = oct_zeros + {3'd0, ~ts16_octet_in[i]};
    tz_sum = {1'b0, ts16_zero_reg} + oct_zeros;
    if (tz_sum > 4'd4)
      tz_sum = 4'd4;
  end

  // alarm detectors; status order ts16los, ts16ais, rmai, ais, rai, red
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      status_reg    <= 6'd0;
      red_cnt_reg   <= 25'd0;
      win_cnt_reg   <= 9'd0;
      win_zero_reg  <= 2'd0;
      prev_low_reg  <= 1'b0;
      prev_high_reg <= 1'b0;
      a_ones_reg    <= 3'd0;
      y_ones_reg    <= 2'd0;
      zrun_reg      <= 5'd0;
      nzrun_reg     <= 5'd0;
      frame_cnt_reg <= 4'd0;
      ts16_zero_reg <= 3'd0;
      prev_few_reg  <= 1'b0;
    end
    else
    begin
      if (oof_in == status_reg[0])
        red_cnt_reg <= 25'd0;
      else if (red_cnt_reg == RED_CYCLES - 1)
      begin
        red_cnt_reg   <= 25'd0;
        status_reg[0] <= oof_in;
      end
      else
        red_cnt_reg <= red_cnt_reg + 25'd1;
      // fixed 512-bit zero-count window
      if (bit_valid_in)
      begin
        win_cnt_reg  <= win_end ? 9'd0 : win_cnt_reg + 9'd1;
        win_zero_reg <= win_end ? 2'd0 : zc_now;
      end
      if (win_end)
      begin
        prev_low_reg  <= win_low;
        prev_high_reg <= !win_low;
        if (!ais_sel)
          status_reg[2] <= win_low ? (oof_in | status_reg[2]) : 1'b0;
        else if (win_low && prev_low_reg)
          status_reg[2] <= 1'b1;
        else if (!win_low && prev_high_reg)
          status_reg[2] <= 1'b0;
      end
      if (a_valid_in)
      begin
        a_ones_reg <= !a_bit_in ? 3'd0 : (a_ones_reg == 3'd4 ? 3'd4 : a_ones_reg + 3'd1);
        // four consecutive ones with remote select zero, one with select one; any zero clears
        if (!a_bit_in)
          status_reg[1] <= 1'b0;
        else if (!rai_sel && a_ones_reg >= `REMOTE_A_ONES - 1)
          status_reg[1] <= 1'b1;
        else if (rai_sel)
          status_reg[1] <= 1'b1;
      end
      // three Y ones set, a zero clears
      if (y_valid_in)
      begin
        y_ones_reg <= !y_bit_in ? 2'd0 : (y_ones_reg == 2'd3 ? 2'd3 : y_ones_reg + 2'd1);
        if (!y_bit_in)
          status_reg[3] <= 1'b0;
        else if (y_ones_reg >= `REMOTE_Y_ONES - 1)
          status_reg[3] <= 1'b1;
      end
      if (ts16_valid_in)
      begin
        // runs of zero and nonzero octets
        if (ts16_octet_in == 8'h00)
        begin
          nzrun_reg <= 5'd0;
          zrun_reg  <= (zrun_reg == 5'd16) ? 5'd16 : zrun_reg + 5'd1;
          if (zrun_reg >= `TS16_RUN_OCTETS - 1)
            status_reg[5] <= 1'b1;
        end
        else
        begin
          zrun_reg  <= 5'd0;
          nzrun_reg <= (nzrun_reg == 5'd16) ? 5'd16 : nzrun_reg + 5'd1;
          if (nzrun_reg >= `TS16_RUN_OCTETS - 1)
            status_reg[5] <= 1'b0;
        end
        frame_cnt_reg <= per_end ? 4'd0 : frame_cnt_reg + 4'd1;
        ts16_zero_reg <= per_end ? 3'd0 : tz_sum[2:0];
      end
      // two few-zero periods set, one busy period clears
      if (per_end)
      begin
        prev_few_reg <= per_few;
        if (per_few && prev_few_reg)
          status_reg[4] <= 1'b1;
        else if (!per_few)
          status_reg[4] <= 1'b0;
      end
    end
  end

  // software registers and sticky flags
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      status_d_reg    <= 6'd0;
      alarm_en_reg    <= 6'd0;
      alarm_flags_reg <= 6'd0;
      crit_reg        <= 2'd0;
      snap_ctrl_reg   <= 2'd0;
      ovf_en0_reg     <= `RESET_BYTE;
      ovf_en1_reg     <= 1'b0;
      ovf_flags0_reg  <= `RESET_BYTE;
      ovf_flags1_reg  <= 1'b0;
      snapshot_out    <= 1'b0;
    end
    else
    begin
      status_d_reg <= status_reg;
      // either-direction change sets flag; set wins over clear
      alarm_flags_reg <= (alarm_flags_reg & ~(wr_flags ? wdata_in[5:0] : 6'd0))
                         | (status_reg ^ status_d_reg);
      // overflow pulses set flags; zero writes leave bits alone
      ovf_flags0_reg <= (ovf_flags0_reg & ~(wr_ovf0 ? wdata_in : 8'h00)) | ovf_in;
      ovf_flags1_reg <= (ovf_flags1_reg & ~(wr_ovf1 & wdata_in[0])) | lcv_ovf_in;
      if (wr_in && addr_in == `IDX_ALARM_ENABLE)
        alarm_en_reg <= wdata_in[5:0];
      if (wr_in && addr_in == `IDX_CRITERIA)
        crit_reg <= {wdata_in[`BIT_ALL_ONES_SEL], wdata_in[`BIT_REMOTE_SEL]};
      if (wr_snap)
        snap_ctrl_reg <= {wdata_in[`BIT_MANUAL_SNAP], wdata_in[`BIT_AUTO_SNAP]};
      if (wr_in && addr_in == `IDX_OVF_ENABLE_0)
        ovf_en0_reg <= wdata_in;
      if (wr_in && addr_in == `IDX_OVF_ENABLE_1)
        ovf_en1_reg <= wdata_in[0];
      // manual rising edge; auto each second tick
      snapshot_out <= (wr_snap && wdata_in[`BIT_MANUAL_SNAP] && !snap_ctrl_reg[1])
                      || (snap_ctrl_reg[0] && sec_tick_in);
    end
  end

  // read mux of this page
  always @*
  begin
    hit_out   = 1'b1;
    rdata_out = 8'h00;
    case (addr_in)
      `IDX_ALARM_STATUS: rdata_out = {2'b00, status_reg};
      `IDX_ALARM_ENABLE: rdata_out = {2'b00, alarm_en_reg};
      `IDX_ALARM_FLAGS:  rdata_out = {2'b00, alarm_flags_reg};
      `IDX_CRITERIA:     rdata_out = {2'b00, crit_reg, 4'h0};
      `IDX_SNAP_CTRL:    rdata_out = {2'b00, snap_ctrl_reg, 4'h0};
      `IDX_OVF_ENABLE_0: rdata_out = ovf_en0_reg;
      `IDX_OVF_ENABLE_1: rdata_out = {7'd0, ovf_en1_reg};
      `IDX_OVF_FLAGS_0:  rdata_out = ovf_flags0_reg;
      `IDX_OVF_FLAGS_1:  rdata_out = {7'd0, ovf_flags1_reg};
      default:           hit_out   = 1'b0;
    endcase
  end

  // per-bit overflow enables; line-code enable bit 0
  assign irq_out = |(alarm_flags_reg & alarm_en_reg) | |(ovf_flags0_reg & ovf_en0_reg)
                   | (ovf_flags1_reg & ovf_en1_reg);
endmodule // e1_link_bank

// ****************************************************************
// top: APB slave, one-second divider, four link pages
// ****************************************************************
module e1_alarm_performance_monitor_event_regs #(
  parameter RED_CYCLES = `RED_PERSIST_MS * `CORE_CLK_KHZ,
  parameter SEC_CYCLES = `SNAP_PERIOD_MS * `CORE_CLK_KHZ
) (
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire [3:0]  oof_in,
  input  wire [3:0]  bit_valid_in,
  input  wire [3:0]  bit_in,
  input  wire [3:0]  a_valid_in,
  input  wire [3:0]  a_bit_in,
  input  wire [3:0]  y_valid_in,
  input  wire [3:0]  y_bit_in,
  input  wire [3:0]  ts16_valid_in,
  input  wire [31:0] ts16_octet_in,
  input  wire [31:0] ovf_in,
  input  wire [3:0]  lcv_ovf_in,
  output wire [3:0]  snapshot_out,
  output wire        int_n_out
);
  reg  [24:0] sec_cnt_reg;
  reg         sec_tick_reg;
  reg         err_reg;
  wire [1:0]  page    = paddr_in[11:10];
  wire [7:0]  idx     = paddr_in[9:2];
  wire        wr_acc  = psel_in && penable_in && pwrite_in;
  wire [31:0] rd_all;
  wire [3:0]  hit_all;
  wire [3:0]  irq_all;

  // one-second enable pulse
  always @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      sec_cnt_reg  <= 25'd0;
      sec_tick_reg <= 1'b0;
    end
    else
    begin
      sec_tick_reg <= (sec_cnt_reg == SEC_CYCLES - 1);
      sec_cnt_reg  <= (sec_cnt_reg == SEC_CYCLES - 1) ? 25'd0 : sec_cnt_reg + 25'd1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : link
      e1_link_bank #(.RED_CYCLES(RED_CYCLES)) u_bank (
        .clk_in        (core_clk_in),
        .rst_n_in      (resetn_in),
        .wr_in         (wr_acc && page == g),
        .addr_in       (idx),
        .wdata_in      (pwdata_in[7:0]),
        .sec_tick_in   (sec_tick_reg),
        .oof_in        (oof_in[g]),
        .bit_valid_in  (bit_valid_in[g]),
        .bit_in        (bit_in[g]),
        .a_valid_in    (a_valid_in[g]),
        .a_bit_in      (a_bit_in[g]),
        .y_valid_in    (y_valid_in[g]),
        .y_bit_in      (y_bit_in[g]),
        .ts16_valid_in (ts16_valid_in[g]),
        .ts16_octet_in (ts16_octet_in[8*g+7:8*g]),
        .ovf_in        (ovf_in[8*g+7:8*g]),
        .lcv_ovf_in    (lcv_ovf_in[g]),
        .rdata_out     (rd_all[8*g+7:8*g]),
        .hit_out       (hit_all[g]),
        .irq_out       (irq_all[g]),
        .snapshot_out  (snapshot_out[g])
      );
    end
  endgenerate

  // read data and error captured in the setup cycle
  always @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      prdata_out <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end
    else if (psel_in && !penable_in)
    begin
      prdata_out <= {24'h00_0000, rd_all[8*page +: 8]};
      err_reg    <= !hit_all[page] || (paddr_in[1:0] != 2'b00);
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && err_reg;
  assign int_n_out   = !(|irq_all);
endmodule // e1_alarm_performance_monitor_event_regs

`default_nettype wire

// [test/e1_alarm_props.sv]
// checker on the top ports of the alarm bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
// ********
// checker
// ********
module e1_alarm_props (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] ovf_in,
  input wire logic [3:0]  lcv_ovf_in,
  input wire logic [3:0]  snapshot_out,
  input wire logic        int_n_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [7:0] ix;
  logic       acc;
  logic       wr0;
  logic       hit;
  logic       go0;
  logic [7:0] en0_reg;
  logic       lcv0_reg;
  logic       man0_reg;
  // access decode
  assign ix  = paddr_in[9:2];
  assign acc = psel_in & penable_in;
  assign wr0 = acc & pwrite_in & (paddr_in[11:10] == 2'h0);
  assign hit = (ix >= 8'hb9 && ix <= 8'hbc) || (ix >= 8'hc2 && ix <= 8'hc6);
  assign go0 = wr0 & (ix == 8'hc2) & pwdata_in[5] & ~man0_reg;
  // page 0 shadows of enables and manual bit
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      en0_reg  <= 8'h00;
      lcv0_reg <= 1'b0;
      man0_reg <= 1'b0;
    end
    else if (wr0)
    begin
      if (ix == 8'hc3)
        en0_reg <= pwdata_in[7:0];
      if (ix == 8'hc4)
        lcv0_reg <= pwdata_in[0];
      if (ix == 8'hc2)
        man0_reg <= pwdata_in[5];
    end
  end
  a_ovf_int_gate: assert property (
    |(ovf_in[7:0] & en0_reg) |=> !int_n_out)
    else $error("enabled overflow left int high");
  a_lcv_int_gate: assert property (
    lcv_ovf_in[0] && lcv0_reg |=> !int_n_out [*2])
    else $error("enabled line-code overflow left int high");
  a_int_by_write: assert property (
    $rose(int_n_out) && $past(resetn_in) |-> $past(acc) && $past(pwrite_in))
    else $error("int released without a write");
  a_int_reset: assert property (!$past(resetn_in) |-> int_n_out)
    else $error("int low after reset");
  a_manual_snap: assert property (go0 |=> snapshot_out[0])
    else $error("no snapshot after manual write");
  a_err_unmapped: assert property (
    acc |-> pslverr_out == (!hit || paddr_in[1:0] != 2'h0))
    else $error("wrong error response");
  a_zero_wait: assert property (psel_in |-> pready_out)
    else $error("ready low");
  a_upper_zero: assert property (acc && !pwrite_in |-> prdata_out[31:8] == 24'h0)
    else $error("read upper bits set");
  c_manual: cover property (go0);
  c_ovf_int: cover property (|(ovf_in[7:0] & en0_reg));
  c_unmapped: cover property (acc && !hit);
endmodule // e1_alarm_props

bind e1_alarm_performance_monitor_event_regs e1_alarm_props u_props (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .ovf_in(ovf_in), .lcv_ovf_in(lcv_ovf_in),
  .snapshot_out(snapshot_out), .int_n_out(int_n_out)
);
`default_nettype wire

// [test/e1_alarm_performance_monitor_event_regs_tb.sv]
// bench for the alarm and monitor register bank
// assumes the bank header constants
`timescale 1ns/1ns
`default_nettype none
`include "e1_alarm_regs.vh"
// ********
// bench
// ********
module e1_alarm_performance_monitor_event_regs_tb;
  localparam int RC = 20;
  localparam int SC = 50;
  localparam logic [7:0] FL = `IDX_ALARM_FLAGS;
  localparam logic [7:0] O0 = `IDX_OVF_FLAGS_0;
  localparam logic [7:0] O1 = `IDX_OVF_FLAGS_1;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  oof = 4'h0;
  logic [3:0]  av = 4'h0;
  logic [3:0]  ab = 4'h0;
  logic [3:0]  yv = 4'h0;
  logic [3:0]  yb = 4'h0;
  logic [3:0]  lcv = 4'h0;
  logic [31:0] ovf = 32'h0;
  logic [3:0]  bv = 4'h0;
  logic [3:0]  bb = 4'h0;
  logic [3:0]  tv = 4'h0;
  logic [31:0] toct = 32'h0;
  logic [31:0] rd_v;
  logic [31:0] seed = 32'h0000_056d;
  logic [7:0]  v;
  logic        err_v;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [3:0]  snap;
  wire         int_n;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          nsnap = 0;
  int          mdl [4][6];
  logic [7:0]  ix [6] = '{8'hbb, 8'hbc, 8'hc2, 8'hc3, 8'hc4, 8'hc5};
  logic [7:0]  msk [6] = '{8'h00, 8'h30, 8'h30, 8'hff, 8'h01, 8'h00};
  // short persistence and second counts
  e1_alarm_performance_monitor_event_regs #(.RED_CYCLES(RC), .SEC_CYCLES(SC)) uut (
    .core_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .oof_in(oof), .bit_valid_in(bv),
    .bit_in(bb), .a_valid_in(av), .a_bit_in(ab), .y_valid_in(yv), .y_bit_in(yb),
    .ts16_valid_in(tv), .ts16_octet_in(toct), .ovf_in(ovf), .lcv_ovf_in(lcv),
    .snapshot_out(snap), .int_n_out(int_n)
  );
  // clock, cycle ceiling and snapshot counter
  initial
    forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      conclude();
    end
  end
  always @(negedge clk)
    if (snap[0] === 1'b1)
      nsnap++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [1:0] pg, input logic [7:0] a,
    input logic [7:0] d);
  begin
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {pg, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd_v  = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  end
  endtask
  task automatic rdc(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] e);
  begin
    apb(1'b0, pg, a, 8'h00);
    chk(rd_v, {24'h0, e});
  end
  endtask
  task automatic ckint(input logic e);
  begin
    @(negedge clk);
    chk(int_n, e);
  end
  endtask
  // one-cycle strobe: a bit, y bit, overflow byte or line-code pulse
  task automatic hit(input int k, input int g, input logic [7:0] d);
  begin
    @(posedge clk);
    case (k)
      0:
      begin
        av <= 4'h1 << g;
        ab <= {4{d[0]}};
      end
      1:
      begin
        yv <= 4'h1 << g;
        yb <= {4{d[0]}};
      end
      2: ovf <= {24'h0, d} << (8 * g);
      default: lcv <= {3'h0, d[0]} << g;
    endcase
    @(posedge clk);
    av  <= 4'h0;
    yv  <= 4'h0;
    ovf <= 32'h0;
    lcv <= 4'h0;
  end
  endtask
  // one fixed window of line bits on link g, its first z bits zero
  task automatic win(input int g, input int z);
  begin
    for (int n = 0; n < `AIS_WINDOW_BITS; n++)
    begin
      @(posedge clk);
      bv <= 4'h1 << g;
      bb <= (n < z) ? 4'h0 : 4'hf;
    end
    @(posedge clk);
    bv <= 4'h0;
  end
  endtask
  // n consecutive ts16 octets of value o on link g
  task automatic tso(input int g, input int n, input logic [7:0] o);
  begin
    repeat (n)
    begin
      @(posedge clk);
      tv   <= 4'h1 << g;
      toct <= {4{o}};
    end
    @(posedge clk);
    tv <= 4'h0;
  end
  endtask
  // read one status bit of a page
  task automatic stb(input logic [1:0] pg, input int b, input logic e);
  begin
    apb(1'b0, pg, `IDX_ALARM_STATUS, 8'h00);
    chk(rd_v[b], e);
  end
  endtask
  task automatic conclude;
  begin
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(2'd0, ix[i], 8'h00);
    for (int p = 0; p < 4; p++)
      for (int i = 0; i < 6; i++)
      begin
        seed = lfsr(seed);
        mdl[p][i] = seed[7:0] & msk[i];
        apb(1'b1, p[1:0], ix[i], seed[7:0]);
      end
    for (int p = 0; p < 16; p++)
      rdc(p[3:2], ix[p % 6], mdl[p[3:2]][p % 6][7:0]);
    for (int p = 0; p < 20; p++)
      apb(1'b1, p[1:0], ix[1 + p / 4], 8'h00);
    seed = lfsr(seed);
    v = seed[7:0] | 8'h80;
    hit(2, 0, v);
    rdc(2'd0, O0, v);
    ckint(1'b1);
    apb(1'b1, 2'd0, `IDX_OVF_ENABLE_0, v & (~v + 8'h01));
    ckint(1'b0);
    apb(1'b1, 2'd0, O0, 8'h00);
    rdc(2'd0, O0, v);
    apb(1'b1, 2'd0, O0, v & (~v + 8'h01));
    rdc(2'd0, O0, v & (v - 8'h01));
    ckint(1'b1);
    rdc(2'd1, O0, 8'h00);
    hit(2, 0, v);
    ckint(1'b0);
    apb(1'b1, 2'd0, O0, 8'hff);
    apb(1'b1, 2'd0, `IDX_OVF_ENABLE_1, 8'h01);
    hit(3, 0, 8'h01);
    ckint(1'b0);
    rdc(2'd0, O1, 8'h01);
    apb(1'b1, 2'd0, `IDX_OVF_ENABLE_1, 8'h00);
    ckint(1'b1);
    apb(1'b1, 2'd0, O1, 8'h01);
    rdc(2'd0, O1, 8'h00);
    for (int k = 1; k <= 4; k++)
    begin
      hit(0, 1, 8'h01);
      rdc(2'd1, FL, (k == 4) ? 8'h02 : 8'h00);
    end
    apb(1'b1, 2'd1, FL, 8'h02);
    apb(1'b1, 2'd1, `IDX_CRITERIA, 8'h10);
    hit(0, 1, 8'h00);
    rdc(2'd1, FL, 8'h02);
    apb(1'b1, 2'd1, FL, 8'h02);
    hit(0, 1, 8'h01);
    rdc(2'd1, FL, 8'h02);
    for (int k = 1; k <= 3; k++)
    begin
      hit(1, 2, 8'h01);
      rdc(2'd2, FL, (k == 3) ? 8'h08 : 8'h00);
    end
    for (int k = 1; k >= 0; k--)
    begin
      oof[3] <= k[0];
      repeat (RC - 4) @(posedge clk);
      rdc(2'd3, FL, 8'h00);
      repeat (6) @(posedge clk);
      rdc(2'd3, FL, 8'h01);
      apb(1'b1, 2'd3, FL, 8'h01);
    end
    nsnap = 0;
    apb(1'b1, 2'd0, `IDX_SNAP_CTRL, 8'h20);
    apb(1'b1, 2'd0, `IDX_SNAP_CTRL, 8'h20);
    repeat (2) @(posedge clk);
    chk(nsnap, 1);
    for (int k = 1; k >= 0; k--)
    begin
      apb(1'b1, 2'd0, `IDX_SNAP_CTRL, {3'h0, k[0], 4'h0});
      repeat (3) @(posedge clk);
      nsnap = 0;
      repeat (3 * SC) @(posedge clk);
      chk(nsnap, 3 * k);
    end
    oof[0] <= 1'b1;
    win(0, 0);
    stb(2'd0, 2, 1'b1);
    win(0, 3);
    stb(2'd0, 2, 1'b0);
    apb(1'b1, 2'd2, `IDX_CRITERIA, 8'h20);
    for (int k = 0; k < 4; k++)
    begin
      win(2, (k < 2) ? 0 : 3);
      stb(2'd2, 2, k[0] ^ k[1]);
    end
    tso(3, 15, 8'h00);
    stb(2'd3, 5, 1'b0);
    tso(3, 1, 8'h00);
    stb(2'd3, 5, 1'b1);
    tso(3, 16, 8'hff);
    stb(2'd3, 5, 1'b0);
    stb(2'd3, 4, 1'b0);
    tso(3, 16, 8'hff);
    stb(2'd3, 4, 1'b1);
    tso(3, 16, 8'h0f);
    stb(2'd3, 4, 1'b0);
    apb(1'b0, 2'd2, 8'h00, 8'h00);
    chk(err_v, 1'b1);
    chk(rd_v, 32'h0);
    conclude();
  end
endmodule // e1_alarm_performance_monitor_event_regs_tb
`default_nettype wire
